// ---- design/hbsc_pkg.sv ----
// Constants and carrier types for the host bridge status/class registers.
// Assumes a byte-addressed configuration access port in front of it.
package hbsc_pkg;

    // ==========================================================
    // Register offsets (configuration byte addresses)
    localparam logic [7:0] HBSC_OFF_STATUS_LO = 8'h06; // Status low byte
    localparam logic [7:0] HBSC_OFF_STATUS_HI = 8'h07; // Status high byte
    localparam logic [7:0] HBSC_OFF_REVISION  = 8'h08; // Silicon revision
    localparam logic [7:0] HBSC_OFF_SUB_CLASS = 8'h0a; // Sub-class code
    localparam logic [7:0] HBSC_OFF_BASE_CLS  = 8'h0b; // Base-class code

    // ==========================================================
    // Status field positions
    localparam int HBSC_BIT_SSE  = 14; // Signalled system error
    localparam int HBSC_BIT_RMA  = 13; // Received master abort
    localparam int HBSC_BIT_RTA  = 12; // Received target abort
    localparam int HBSC_HI_BASE  = 8;  // Status bit held in wdata bit 0

    // ==========================================================
    // Fixed values
    localparam logic [15:0] HBSC_STATUS_RESET = 16'h0090; // Reset/fixed bits
    localparam logic [7:0]  HBSC_SUB_CLASS    = 8'h00;    // Host bridge
    localparam logic [7:0]  HBSC_BASE_CLASS   = 8'h06;    // Bridge device
    localparam logic [7:0]  HBSC_CMD_SERR_BIT = 8'h08;    // Command bit index
    localparam logic [7:0]  HBSC_ZERO_BYTE    = 8'h00;    // Unmapped read data

    // ==========================================================
    // Sticky error flags travelling together
    typedef struct packed {
        logic signalled_system_error_flag;  // Signalled system error
        logic rma;  // Received master abort
        logic rta;  // Received target abort
    } hbsc_flags_t;

endpackage

// ---- design/hbsc_regs.sv ----
// Status, revision and class-code registers of the host bridge function.
// Assumes byte-wide configuration accesses, one cycle, synchronous to clock;
// event inputs are single-cycle pulses from the hub completion logic.
`timescale 1ns/100ps
module hbsc_regs
    import hbsc_pkg::*;
#(
    // Arbitrary neutral revision value
    parameter logic [7:0] REVISION_ID = 8'h01
)(
    input  wire logic       ref_clk_i,       // Core clock, 125 MHz
    input  wire logic       reset_n_i,       // Async reset, active low
    input  wire logic [7:0] cfg_addr_i,      // Configuration byte offset
    input  wire logic       cfg_wr_i,        // Write strobe
    input  wire logic [7:0] cfg_wdata_i,     // Write data
    input  wire logic [7:0] cfg_rdata_sel_i, // Read address
    output logic      [7:0] cfg_rdata_o,     // Registered read data
    input  wire logic       error_message_enable_i, // Command bit 8
    input  wire logic       error_event_i,   // Enabled error condition
    input  wire logic       master_abort_i,  // Master abort completion
    input  wire logic       target_abort_i,  // Target abort completion
    output logic            serr_message_o,  // System-error message pulse
    output logic [15:0]     bridge_status_o  // Live status view
);

    // ==========================================================
    // Sticky flags
    hbsc_flags_t flags_ff;     // Stored flags
    hbsc_flags_t nxt_flags;    // Next flags
    logic        serr_msg_ff;  // Message strobe register
    logic        wr_hi;        // Write to status high byte
    logic        send_msg;     // Message goes out next cycle
    logic [15:0] status_view;  // Composed status word

    // Message only when the function's enable is set
    assign send_msg = error_event_i && error_message_enable_i;
    assign wr_hi    = cfg_wr_i && (cfg_addr_i == HBSC_OFF_STATUS_HI);

    // Set wins over clear so an event coinciding with a clear is kept
    always_comb
    begin
        nxt_flags = flags_ff;
        if (wr_hi)
        begin
            // Writing one clears, zero leaves the flag alone
            if (cfg_wdata_i[HBSC_BIT_SSE-HBSC_HI_BASE])
                nxt_flags.signalled_system_error_flag = 1'b0;
            if (cfg_wdata_i[HBSC_BIT_RMA-HBSC_HI_BASE])
                nxt_flags.rma = 1'b0;
            if (cfg_wdata_i[HBSC_BIT_RTA-HBSC_HI_BASE])
                nxt_flags.rta = 1'b0;
        end
        if (send_msg)       nxt_flags.signalled_system_error_flag = 1'b1;
        if (master_abort_i) nxt_flags.rma = 1'b1;
        if (target_abort_i) nxt_flags.rta = 1'b1;
    end

    // Flag storage
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            flags_ff <= '0;
        else
            flags_ff <= nxt_flags;
    end

    // Message strobe toward the hub, one cycle per event
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            serr_msg_ff <= 1'b0;
        else
            serr_msg_ff <= send_msg;
    end
    assign serr_message_o = serr_msg_ff;

    // ==========================================================
    // Status composition: hardwired bits come from the fixed pattern
    always_comb
    begin
        // Fixed pattern holds 1s at 7 and 4, 0 at 15,11,10:9,8,6:5,3:0
        status_view = HBSC_STATUS_RESET;
        status_view[HBSC_BIT_SSE] = flags_ff.signalled_system_error_flag;
        status_view[HBSC_BIT_RMA] = flags_ff.rma;
        status_view[HBSC_BIT_RTA] = flags_ff.rta;
    end
    assign bridge_status_o = status_view;

    // ==========================================================
    // Read mux; revision and class codes are constants, writes ignored
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cfg_rdata_o <= HBSC_ZERO_BYTE;
        else
        begin
            case (cfg_rdata_sel_i)
                HBSC_OFF_STATUS_LO: cfg_rdata_o <= status_view[7:0];
                HBSC_OFF_STATUS_HI: cfg_rdata_o <= status_view[15:8];
                HBSC_OFF_REVISION:  cfg_rdata_o <= REVISION_ID;
                HBSC_OFF_SUB_CLASS: cfg_rdata_o <= HBSC_SUB_CLASS;
                HBSC_OFF_BASE_CLS:  cfg_rdata_o <= HBSC_BASE_CLASS;
                default:            cfg_rdata_o <= HBSC_ZERO_BYTE;
            endcase
        end
    end

    // ==========================================================
    // Checks
    chk_sse_sets: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        send_msg |=> flags_ff.signalled_system_error_flag && serr_message_o)
        else $error("system error flag not set");
    chk_sse_clear: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        wr_hi && cfg_wdata_i[6] && !send_msg |=> !flags_ff.signalled_system_error_flag)
        else $error("system error flag not cleared");
    chk_sse_keep: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        flags_ff.signalled_system_error_flag && !(wr_hi && cfg_wdata_i[6]) |=> flags_ff.signalled_system_error_flag)
        else $error("system error flag lost");
    chk_rma_sets: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        master_abort_i |=> bridge_status_o[13])
        else $error("master abort flag not set");
    chk_rta_sets: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        target_abort_i |=> bridge_status_o[12])
        else $error("target abort flag not set");
    chk_fixed_bits: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        (bridge_status_o & 16'h8fff) == 16'h0090)
        else $error("hardwired status bits wrong");
    chk_no_msg_off: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !error_message_enable_i && !flags_ff.signalled_system_error_flag && !(master_abort_i)
        |=> !flags_ff.signalled_system_error_flag)
        else $error("system error set while disabled");
    chk_class_read: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        cfg_rdata_sel_i == 8'h0b |=> cfg_rdata_o == 8'h06)
        else $error("base class read wrong");
    chk_sub_read: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        cfg_rdata_sel_i == 8'h0a |=> cfg_rdata_o == 8'h00)
        else $error("sub class read wrong");


    // ==========================================================
    // Abort flag clearing and holding
    // A clear is only judged when no event lands in the same cycle,
    // because the event wins and keeps the flag set.
    chk_rma_clear: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        wr_hi && cfg_wdata_i[5] && !master_abort_i |=> !flags_ff.rma)
        else $error("master abort flag not cleared");

    // A write of zero, or no write, must leave the flag set
    chk_rma_keep: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        flags_ff.rma && !(wr_hi && cfg_wdata_i[5]) |=> flags_ff.rma)
        else $error("master abort flag lost");

    // Target abort clear mirrors the master abort clear
    chk_rta_clear: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        wr_hi && cfg_wdata_i[4] && !target_abort_i |=> !flags_ff.rta)
        else $error("target abort flag not cleared");

    // Target abort flag is sticky until written with one
    chk_rta_keep: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        flags_ff.rta && !(wr_hi && cfg_wdata_i[4]) |=> flags_ff.rta)
        else $error("target abort flag lost");

    // ==========================================================
    // Message gating
    // No message may leave while the enable is low or nothing happened
    chk_msg_gated: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !(error_event_i && error_message_enable_i) |=> !serr_message_o)
        else $error("message sent without enabled event");

    // ==========================================================
    // Hardwired status bits, one check per field so a failure
    // points straight at the field that went wrong
    chk_parity_zero: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !bridge_status_o[15])
        else $error("parity error flag not zero");

    // Signalled target abort is not implemented
    chk_sta_zero: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !bridge_status_o[11])
        else $error("signalled target abort not zero");

    // Select timing reports fast decode
    chk_sel_timing: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        bridge_status_o[10:9] == 2'b00)
        else $error("select timing field not fast");

    // Data parity flag is not implemented
    chk_dpar_zero: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !bridge_status_o[8])
        else $error("data parity flag not zero");

    // Fast back-to-back capability is always advertised
    chk_fast_back_to_back_cap_one: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        bridge_status_o[7])
        else $error("fast back-to-back bit not one");

    // Capability list is always present
    chk_caplist_one: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        bridge_status_o[4])
        else $error("capability list bit not one");

    // Reserved bits stay zero whatever software writes
    chk_rsvd_zero: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        bridge_status_o[6:5] == 2'b00 && bridge_status_o[3:0] == 4'h0)
        else $error("reserved status bits not zero");

    // ==========================================================
    // Read port
    // Read data lags the select by one edge, so compare against the
    // status as it stood when the select was sampled
    chk_read_hi: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        cfg_rdata_sel_i == HBSC_OFF_STATUS_HI
        |=> cfg_rdata_o == $past(bridge_status_o[15:8]))
        else $error("status high byte read wrong");

    // Low status byte holds only fixed bits
    chk_read_lo: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        cfg_rdata_sel_i == HBSC_OFF_STATUS_LO |=> cfg_rdata_o == 8'h90)
        else $error("status low byte read wrong");

    // Revision ignores writes and returns the parameter
    chk_rev_read: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        cfg_rdata_sel_i == HBSC_OFF_REVISION |=> cfg_rdata_o == REVISION_ID)
        else $error("revision read wrong");

    // Registers outside this block read as zero
    chk_unmap_read: assert property (@(posedge ref_clk_i)
        disable iff (!reset_n_i)
        !(cfg_rdata_sel_i inside {[8'h06:8'h08], 8'h0a, 8'h0b})
        |=> cfg_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // ==========================================================
    // Coverage of the main scenarios
    // Limitation: events arriving with the enable low are dropped, so a
    // later enable does not replay them; covers below show only the enabled path.
    cov_sse_set:   cover property (@(posedge ref_clk_i) send_msg);
    cov_rma_set:   cover property (@(posedge ref_clk_i)
        !flags_ff.rma ##1 flags_ff.rma);
    cov_read_hi:   cover property (@(posedge ref_clk_i)
        cfg_rdata_sel_i == HBSC_OFF_STATUS_HI && flags_ff.rta);
    cov_set_clear: cover property (@(posedge ref_clk_i)
        wr_hi && master_abort_i);
    cov_rta_clear: cover property (@(posedge ref_clk_i)
        flags_ff.rta ##1 !flags_ff.rta);

endmodule // hbsc_regs

// ---- verification/tb_top.sv ----
// Self-checking bench for the host bridge status and class registers.
// Assumes hbsc_pkg and hbsc_regs are compiled first; inputs move at negedge.
`timescale 1ns/100ps
module tb_top
    import hbsc_pkg::*;
;
    // ==========================================================
    // Stimulus and observation
    localparam logic [7:0] REV = 8'h5a; // Arbitrary revision value
    logic        ref_clk_i = 1'b0;      // Core clock
    logic        reset_n_i = 1'b0;      // Reset, active low
    logic [7:0]  addr = 8'h00;          // Write offset
    logic        wr = 1'b0;             // Write strobe
    logic [7:0]  wdata = 8'h00;         // Write data
    logic [7:0]  sel = 8'h00;           // Read offset
    logic        en = 1'b0;             // Error message enable
    logic        err = 1'b0;            // Error event
    logic        ma = 1'b0;             // Master abort
    logic        ta = 1'b0;             // Target abort
    logic [7:0]  rdata;                 // Read data
    logic        serr;                  // Message pulse
    logic [15:0] status;                // Status view
    int          num_errors = 0;        // Mismatches
    int          tests_run = 0;         // Comparisons

    hbsc_regs #(.REVISION_ID(REV)) dut_u (.ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i), .cfg_addr_i(addr), .cfg_wr_i(wr),
        .cfg_wdata_i(wdata), .cfg_rdata_sel_i(sel), .cfg_rdata_o(rdata),
        .error_message_enable_i(en), .error_event_i(err),
        .master_abort_i(ma), .target_abort_i(ta),
        .serr_message_o(serr), .bridge_status_o(status));

    // ==========================================================
    // Clock: 8 ns period
    initial
    begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // ==========================================================
    // Compare and bus tasks
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        chk16({8'h00, got}, {8'h00, exp});
    endtask
    // One-cycle write; flags have landed by the closing negedge
    task automatic wrb(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i) {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge ref_clk_i) wr = 1'b0;
    endtask
    task automatic rdb(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk_i) sel = a;
        @(negedge ref_clk_i) chk8(rdata, exp);
    endtask
    // One-cycle event pulses, message pulse checked the cycle after
    task automatic ev(input logic e, m, t, xs);
        @(negedge ref_clk_i) {err, ma, ta} = {e, m, t};
        @(negedge ref_clk_i) {err, ma, ta} = 3'b000;
        chk8({7'h00, serr}, {7'h00, xs});
    endtask
    task automatic conclude();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk16(status, 16'h0090);
        rdb(8'h06, 8'h90);
        rdb(8'h07, 8'h00);
        rdb(8'h0c, 8'h00);
        wrb(8'h08, 8'hff);
        rdb(8'h08, REV);
        wrb(8'h0a, 8'hff);
        rdb(8'h0a, 8'h00);
        wrb(8'h0b, 8'hff);
        rdb(8'h0b, 8'h06);
    endtask
    task automatic t_serr();
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        chk16(status, 16'h0090);
        en = 1'b1;
        ev(1'b1, 1'b0, 1'b0, 1'b1);
        chk16(status, 16'h4090);
        wrb(8'h07, 8'h00);
        chk16(status, 16'h4090);
        wrb(8'h07, 8'h40);
        chk16(status, 16'h0090);
    endtask
    task automatic t_abort();
        ev(1'b0, 1'b1, 1'b0, 1'b0);
        chk16(status, 16'h2090);
        ev(1'b0, 1'b0, 1'b1, 1'b0);
        chk16(status, 16'h3090);
        wrb(8'h06, 8'hff);
        chk16(status, 16'h3090);
        wrb(8'h07, 8'h8f);
        chk16(status, 16'h3090);
        rdb(8'h07, 8'h30);
        rdb(8'h06, 8'h90);
        wrb(8'h07, 8'h20);
        chk16(status, 16'h1090);
        // Set wins over a clear landing in the same cycle
        @(negedge ref_clk_i) {ta, addr, wdata, wr} = {1'b1, 8'h07, 8'h10, 1'b1};
        @(negedge ref_clk_i) {ta, wr} = 2'b00;
        chk16(status, 16'h1090);
        wrb(8'h07, 8'h10);
        chk16(status, 16'h0090);
    endtask

    // Mid-run reset must drop every sticky flag and the read data
    task automatic t_rereset();
        ev(1'b1, 1'b1, 1'b1, 1'b1);
        chk16(status, 16'h7090);
        rdb(8'h0b, 8'h06);
        @(negedge ref_clk_i) reset_n_i = 1'b0;
        @(negedge ref_clk_i) chk16(status, 16'h0090);
        chk8(rdata, 8'h00);
        reset_n_i = 1'b1;
        rdb(8'h07, 8'h00);
    endtask

    initial
    begin
        repeat (6) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        t_reset();
        t_serr();
        t_abort();
        t_rereset();
        conclude();
    end
endmodule // tb_top
